// File: rtl/sleep_wakeup_control.sv
`timescale 1ns/1ps
`default_nettype none
module sleep_wakeup_control #(
	parameter int WDT_TIMEOUT = sleep_pkg::WDT_TIMEOUT,
	parameter int RESTART     = sleep_pkg::OSC_RESTART
) (
	input  wire logic                  clk,
	input  wire logic                  sys_rst,
	input  wire logic                  master_clear_pin,
	input  wire logic                  wdt_enable,
	input  wire logic                  watchdog_clear_op,
	input  wire logic                  sleep_op,
	input  wire logic [12:0]           sleep_pc,
	input  wire logic                  global_irq_enable,
	input  wire sleep_pkg::irq_s       irq,
	input  wire sleep_pkg::pin_drive_s core_pins,
	output sleep_pkg::pin_drive_s      pins,
	output logic                       power_down_flag,
	output logic                       timeout_flag,
	output logic                       osc_enable,
	output logic                       phase_clk_enable,
	output logic                       asleep,
	output logic                       core_reset,
	output logic                       fetch_valid,
	output logic [12:0]                fetch_addr,
	output logic                       exec_prefetch,
	output logic                       irq_vector_take,
	output logic [12:0]                irq_vector_addr
);
	// ==========================================
	// Elaboration checks
	// The restart counter is eight bits wide
	if (RESTART < 1 || RESTART > 255)
	begin
		$error("sleep_wakeup_control: RESTART out of range");
	end
	// A watchdog that times out at once could never be cleared
	if (WDT_TIMEOUT < 2)
	begin
		$error("sleep_wakeup_control: WDT_TIMEOUT out of range");
	end

	// Sequencer state and status flags
	sleep_pkg::sleep_state_e state_q;
	sleep_pkg::sleep_state_e state_d;
	logic                    pwrdn_q;
	logic                    pwrdn_d;
	logic                    to_q;
	logic                    to_d;
	logic                    osc_q;
	logic                    osc_d;

	// One-cycle strobes, the prefetch address, the pending vector and the restart count
	logic                    rst_q;
	logic                    rst_d;
	logic                    fetch_q;
	logic                    fetch_d;
	logic [12:0]             faddr_q;
	logic [12:0]             faddr_d;
	logic                    exec_q;
	logic                    exec_d;
	logic                    vec_q;
	logic                    vec_d;
	logic                    vec_pend_q;
	logic                    vec_pend_d;
	logic [7:0]              wait_q;
	logic [7:0]              wait_d;

	// Output flops
	logic                    asleep_q;
	logic                    asleep_d;
	logic                    phase_q;
	logic                    phase_d;
	logic [12:0]             vaddr_q;
	logic [12:0]             vaddr_d;

	// Combinational helpers
	logic                    edge_wake;
	logic                    port_wake;
	logic                    conv_wake;
	logic                    irq_wake;
	logic                    wake_wdt;
	logic                    wdt_clear;
	logic                    wdt_to;
	logic                    sleep_real;

	// ==========================================
	// Interrupt wake qualification
	// Each source needs its own enable; the global enable never blocks wake.
	assign edge_wake = irq.edge_flag & irq.edge_en;
	assign port_wake = irq.port_flag & irq.port_en;
	// Phase clocks are stopped in sleep, so only a converter on its own
	// RC clock can still finish a conversion and raise its flag.
	assign conv_wake = irq.conv_flag & irq.conv_en & irq.conv_rc_clk;

	always_comb
	begin
		irq_wake = edge_wake | port_wake | conv_wake;
	end

	// Sleep only takes effect with no interrupt already pending
	assign sleep_real = (state_q == sleep_pkg::ST_RUN) && sleep_op && !irq_wake;
	assign wdt_clear  = sleep_real || watchdog_clear_op;

	// Watchdog time-out counts only with the watchdog enabled
	assign wake_wdt   = wdt_to && wdt_enable;

	// ==========================================
	// Watchdog
	// Counts on the core clock as a stand-in for its own RC clock; the
	// model keeps it running while the oscillator driver is off.
	wake_watchdog #(
		.WIDTH   (sleep_pkg::WDT_WIDTH),
		.TIMEOUT (WDT_TIMEOUT)
	) u_wdt (
		.clk     (clk),
		.sys_rst (sys_rst),
		.enable  (wdt_enable),
		.clear   (wdt_clear),
		.timeout (wdt_to)
	);

	// ==========================================
	// Pin hold while asleep
	pin_hold u_pins (
		.clk     (clk),
		.sys_rst (sys_rst),
		.freeze  (state_d != sleep_pkg::ST_RUN),
		.live    (core_pins),
		.pins    (pins)
	);

	// ==========================================
	// Sequencer next state
	always_comb
	begin
		state_d    = state_q;
		pwrdn_d    = pwrdn_q;
		to_d       = to_q;
		osc_d      = osc_q;
		rst_d      = 1'b0;
		fetch_d    = 1'b0;
		faddr_d    = faddr_q;
		exec_d     = 1'b0;
		vec_d      = 1'b0;
		vec_pend_d = vec_pend_q;
		wait_d     = wait_q;
		case (state_q)
			sleep_pkg::ST_RUN:
			begin
				// Running: clear op, watchdog reset or sleep entry
				if (watchdog_clear_op)
				begin
					to_d    = 1'b1;
					pwrdn_d = 1'b1;
				end
				// Time-out beats a clear in the same cycle
				if (wake_wdt)
				begin
					rst_d = 1'b1;
					to_d  = 1'b0;
				end
				else if (sleep_real)
				begin
					pwrdn_d = 1'b0;
					to_d    = 1'b1;
					osc_d   = 1'b0;
					fetch_d = 1'b1;
					faddr_d = sleep_pc + 13'h0001;
					state_d = sleep_pkg::ST_SLEEP;
				end
			end
			sleep_pkg::ST_SLEEP:
			begin
				// Sleep has completed; any wake now comes after it
				// Watchdog wins a tie so its flag names the cause
				if (wake_wdt)
				begin
					to_d       = 1'b0;
					vec_pend_d = 1'b0;
					wait_d     = 8'(RESTART);
					osc_d      = 1'b1;
					state_d    = sleep_pkg::ST_RESTART;
				end
				else if (irq_wake)
				begin
					vec_pend_d = global_irq_enable;
					wait_d     = 8'(RESTART);
					osc_d      = 1'b1;
					state_d    = sleep_pkg::ST_RESTART;
				end
			end
			sleep_pkg::ST_RESTART:
			begin
				// Oscillator settles before phase clocks restart
				if (wait_q <= 8'h01)
					state_d = sleep_pkg::ST_RESUME;
				else
					wait_d = wait_q - 8'h01;
			end
			sleep_pkg::ST_RESUME:
			begin
				// Phase clocks back; prefetched word runs next
				exec_d     = 1'b1;
				vec_d      = vec_pend_q;
				vec_pend_d = 1'b0;
				state_d    = sleep_pkg::ST_RUN;
			end
			default:
				state_d = sleep_pkg::ST_RUN;
		endcase
		// External reset wins over the state and strobes, asleep or not; power-down and time-out flag updates still take effect
		if (!master_clear_pin)
		begin
			rst_d      = 1'b1;
			osc_d      = 1'b1;
			state_d    = sleep_pkg::ST_RUN;
			vec_pend_d = 1'b0;
			fetch_d    = 1'b0;
			exec_d     = 1'b0;
			vec_d      = 1'b0;
		end
	end

	// ==========================================
	// Sequencer registers; reset is power-up
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			state_q    <= sleep_pkg::ST_RUN;
			pwrdn_q    <= 1'b1;
			to_q       <= 1'b1;
			osc_q      <= 1'b1;
			rst_q      <= 1'b1;
			fetch_q    <= 1'b0;
			faddr_q    <= sleep_pkg::PC_RESET;
			exec_q     <= 1'b0;
			vec_q      <= 1'b0;
			vec_pend_q <= 1'b0;
			wait_q     <= 8'h00;
		end
		else
		begin
			state_q    <= state_d;
			pwrdn_q    <= pwrdn_d;
			to_q       <= to_d;
			osc_q      <= osc_d;
			rst_q      <= rst_d;
			fetch_q    <= fetch_d;
			faddr_q    <= faddr_d;
			exec_q     <= exec_d;
			vec_q      <= vec_d;
			vec_pend_q <= vec_pend_d;
			wait_q     <= wait_d;
		end
	end

	// ==========================================
	// Outputs, all from flops
	// Asleep covers restart and resume so the core stays parked until
	// the phase clocks run again.
	always_comb
	begin
		asleep_d = state_d != sleep_pkg::ST_RUN;
		phase_d  = state_d == sleep_pkg::ST_RUN || state_d == sleep_pkg::ST_RESUME;
		vaddr_d  = sleep_pkg::IRQ_VECTOR;
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			asleep_q <= 1'b0;
			phase_q  <= 1'b1;
			vaddr_q  <= sleep_pkg::IRQ_VECTOR;
		end
		else
		begin
			asleep_q <= asleep_d;
			phase_q  <= phase_d;
			vaddr_q  <= vaddr_d;
		end
	end

	// Ports straight from the flops
	assign power_down_flag  = pwrdn_q;
	assign timeout_flag     = to_q;
	assign osc_enable       = osc_q;
	assign phase_clk_enable = phase_q;
	assign asleep           = asleep_q;
	assign core_reset       = rst_q;
	assign fetch_valid      = fetch_q;
	assign fetch_addr       = faddr_q;
	assign exec_prefetch    = exec_q;
	assign irq_vector_take  = vec_q;
	assign irq_vector_addr  = vaddr_q;
endmodule
`default_nettype wire

// File: rtl/sleep_pkg.sv
package sleep_pkg;

	// ==========================================
	// Status layout and reset values
	localparam int          PWRDN_BIT    = 3;
	localparam int          TMOUT_BIT    = 4;
	localparam logic [12:0] IRQ_VECTOR   = 13'h0004;
	localparam logic [12:0] PC_RESET     = 13'h0000;
	localparam int          WDT_WIDTH    = 16;
	localparam int          WDT_TIMEOUT  = 16'h0400;
	localparam int          OSC_RESTART  = 4;
	localparam int          GPIO_WIDTH   = 6;

	// ==========================================
	// Wake controller states
	typedef enum logic [1:0] {
		ST_RUN     = 2'b00,
		ST_SLEEP   = 2'b01,
		ST_RESTART = 2'b10,
		ST_RESUME  = 2'b11
	} sleep_state_e;

	// Interrupt request group
	typedef struct packed {
		logic edge_flag;
		logic edge_en;
		logic port_flag;
		logic port_en;
		logic conv_flag;
		logic conv_en;
		logic conv_rc_clk;
	} irq_s;

	// Pin drive group
	typedef struct packed {
		logic [GPIO_WIDTH-1:0] out;
		logic [GPIO_WIDTH-1:0] oe_n;
	} pin_drive_s;

endpackage

// File: rtl/wake_watchdog.sv
`timescale 1ns/1ps
`default_nettype none
module wake_watchdog #(
	parameter int WIDTH   = sleep_pkg::WDT_WIDTH,
	parameter int TIMEOUT = sleep_pkg::WDT_TIMEOUT
) (
	input  wire logic clk,
	input  wire logic sys_rst,
	input  wire logic enable,
	input  wire logic clear,
	output logic      timeout
);
	// Refuse a timeout the counter cannot reach
	if (TIMEOUT < 2 || TIMEOUT >= (1 << WIDTH))
	begin
		$error("wake_watchdog: TIMEOUT out of range");
	end

	logic [WIDTH-1:0] count_q;
	logic [WIDTH-1:0] count_d;
	logic             timeout_q;
	logic             timeout_d;

	// ==========================================
	// Counter zeroed by a clear or while disabled; wraps at time-out
	always_comb
	begin
		count_d   = count_q + 1'b1;
		timeout_d = 1'b0;
		if (!enable || clear)
			count_d = '0;
		else if (count_q == WIDTH'(TIMEOUT - 1))
		begin
			count_d   = '0;
			timeout_d = 1'b1;
		end
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			count_q   <= '0;
			timeout_q <= 1'b0;
		end
		else
		begin
			count_q   <= count_d;
			timeout_q <= timeout_d;
		end
	end

	assign timeout = timeout_q;
endmodule
`default_nettype wire

// File: rtl/pin_hold.sv
`timescale 1ns/1ps
`default_nettype none
module pin_hold (
	input  wire logic                  clk,
	input  wire logic                  sys_rst,
	input  wire logic                  freeze,
	input  wire sleep_pkg::pin_drive_s live,
	output sleep_pkg::pin_drive_s      pins
);
	sleep_pkg::pin_drive_s pins_q;
	sleep_pkg::pin_drive_s pins_d;

	// ==========================================
	// Pins follow the core unless frozen for sleep
	always_comb
	begin
		pins_d = freeze ? pins_q : live;
	end

	// Reset floats every pin (enable is low-active)
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			pins_q.out  <= '0;
			pins_q.oe_n <= '1;
		end
		else
			pins_q <= pins_d;
	end

	assign pins = pins_q;
endmodule
`default_nettype wire

// File: tb/sleep_wakeup_properties.sv
`timescale 1ns/1ps
`default_nettype none
module sleep_wakeup_properties (
	input wire logic                  clk,
	input wire logic                  sys_rst,
	input wire logic                  master_clear_pin,
	input wire logic                  sleep_op,
	input wire logic [12:0]           sleep_pc,
	input wire sleep_pkg::irq_s       irq,
	input wire sleep_pkg::pin_drive_s pins,
	input wire logic                  power_down_flag,
	input wire logic                  timeout_flag,
	input wire logic                  osc_enable,
	input wire logic                  phase_clk_enable,
	input wire logic                  asleep,
	input wire logic                  core_reset,
	input wire logic                  fetch_valid,
	input wire logic [12:0]           fetch_addr,
	input wire logic                  exec_prefetch,
	input wire logic                  irq_vector_take,
	input wire logic [12:0]           irq_vector_addr
);
	// ==========================================
	// Enabled request, global enable ignored
	wire logic pend;
	assign pend = irq.edge_flag & irq.edge_en | irq.port_flag & irq.port_en
		| irq.conv_flag & irq.conv_en & irq.conv_rc_clk;

	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);

	// Restart span written as 4: bench keeps the default
	a_sleep_entry_flags: assert property (sleep_op && !asleep && master_clear_pin && !pend |=> !power_down_flag && timeout_flag && !osc_enable && asleep) else $error("sleep entry flags wrong");
	a_sleep_prefetch: assert property (sleep_op && !asleep && master_clear_pin && !pend |=> fetch_valid && fetch_addr == $past(sleep_pc) + 13'h1) else $error("prefetch address wrong");
	a_pending_nop: assert property (sleep_op && !asleep && pend |=> $stable(power_down_flag) && !asleep) else $error("pending sleep not a nop");
	a_wake_prompt: assert property (asleep && !osc_enable && pend && master_clear_pin |=> osc_enable) else $error("no wake on request");
	a_restart_order: assert property ($rose(osc_enable) && asleep |-> !phase_clk_enable [*4] ##1 phase_clk_enable ##1 exec_prefetch) else $error("restart order wrong");
	a_vector_addr: assert property (irq_vector_take |-> exec_prefetch && irq_vector_addr == 13'h0004) else $error("vector wrong");
	a_pins_hold: assert property (asleep && $past(asleep) |-> $stable(pins)) else $error("pins moved in sleep");
	a_ext_reset: assert property (!master_clear_pin |=> core_reset && !asleep && osc_enable) else $error("external clear gave no reset");
	a_wake_no_reset: assert property (asleep && master_clear_pin |=> !core_reset) else $error("wake gave reset");
endmodule

bind sleep_wakeup_control sleep_wakeup_properties chk (.clk, .sys_rst, .master_clear_pin, .sleep_op, .sleep_pc,
	.irq, .pins, .power_down_flag, .timeout_flag, .osc_enable, .phase_clk_enable, .asleep, .core_reset,
	.fetch_valid, .fetch_addr, .exec_prefetch, .irq_vector_take, .irq_vector_addr);
`default_nettype wire

// File: tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic clk, sys_rst, master_clear_pin, wdt_enable, watchdog_clear_op, sleep_op, global_irq_enable;
	logic [12:0] sleep_pc, fetch_addr, irq_vector_addr;
	sleep_pkg::irq_s irq;
	sleep_pkg::pin_drive_s core_pins, pins;
	logic power_down_flag, timeout_flag, osc_enable, phase_clk_enable, asleep, core_reset;
	logic fetch_valid, exec_prefetch, irq_vector_take;
	int fail_count, n_compared, cyc, i;

	// Short watchdog keeps the run brief
	sleep_wakeup_control #(.WDT_TIMEOUT(16)) dut (.clk, .sys_rst, .master_clear_pin, .wdt_enable,
		.watchdog_clear_op, .sleep_op, .sleep_pc, .global_irq_enable, .irq, .core_pins, .pins,
		.power_down_flag, .timeout_flag, .osc_enable, .phase_clk_enable, .asleep, .core_reset,
		.fetch_valid, .fetch_addr, .exec_prefetch, .irq_vector_take, .irq_vector_addr);

	// ==========================================
	// Clock and hang guard
	initial
	begin
		clk = 1'h0;
		forever #2.5 clk = ~clk;
	end
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			fail_count++;
			end_of_test;
		end
	end

	// ==========================================
	// Access tasks
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic chk(input string s, input logic [12:0] e, input logic [12:0] g);
		n_compared++;
		if (g !== e)
		begin
			$display("MISMATCH %s exp %h got %h", s, e, g);
			fail_count++;
		end
	endtask
	task automatic go_sleep(input logic [12:0] pc);
		sleep_op = 1'h1;
		sleep_pc = pc;
		step(1);
		sleep_op = 1'h0;
	endtask
	task automatic clr_wdt;
		watchdog_clear_op = 1'h1;
		step(1);
		watchdog_clear_op = 1'h0;
	endtask
	// Bounded wait: a missing wake shows as a mismatch
	task automatic wait_exec;
		for (i = 0; i < 40 && exec_prefetch !== 1'h1; i++)
			step(1);
		chk("exec", 1'h1, exec_prefetch);
	endtask
	task automatic end_of_test;
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// ==========================================
	// Test sequence
	initial
	begin
		{sys_rst, master_clear_pin} = 2'h3;
		{wdt_enable, watchdog_clear_op, sleep_op, global_irq_enable} = 4'h0;
		{sleep_pc, irq} = '0;
		core_pins = 12'h5c1;
		step(6);
		sys_rst = 1'h0;
		step(2);
		chk("power_down", 1'h1, power_down_flag);
		chk("osc", 1'h1, osc_enable);
		$display("reset test done");
		go_sleep(13'h0100);
		chk("power_down", 1'h0, power_down_flag);
		chk("timeout", 1'h1, timeout_flag);
		chk("fetch_valid", 1'h1, fetch_valid);
		chk("fetch", 13'h0101, fetch_addr);
		core_pins = 12'h03f;
		step(3);
		chk("pins", 12'h5c1, pins);
		chk("osc", 1'h0, osc_enable);
		chk("phase", 1'h0, phase_clk_enable);
		global_irq_enable = 1'h1;
		{irq.edge_flag, irq.edge_en} = 2'h3;
		wait_exec;
		chk("vec", 1'h1, irq_vector_take);
		chk("vec_addr", 13'h0004, irq_vector_addr);
		irq = '0;
		$display("edge wake test done");
		global_irq_enable = 1'h0;
		go_sleep(13'h1fff);
		chk("fetch", 13'h0000, fetch_addr);
		{irq.edge_flag, irq.conv_flag, irq.conv_en} = 3'h7;
		step(10);
		chk("asleep", 1'h1, asleep);
		irq.conv_rc_clk = 1'h1;
		wait_exec;
		chk("vec", 1'h0, irq_vector_take);
		irq = '0;
		$display("converter wake test done");
		clr_wdt;
		chk("power_down", 1'h1, power_down_flag);
		{irq.port_flag, irq.port_en} = 2'h3;
		go_sleep(13'h0040);
		chk("power_down", 1'h1, power_down_flag);
		chk("asleep", 1'h0, asleep);
		irq = '0;
		$display("pending nop test done");
		{wdt_enable, global_irq_enable} = 2'h3;
		clr_wdt;
		go_sleep(13'h0200);
		wait_exec;
		chk("timeout", 1'h0, timeout_flag);
		chk("vec", 1'h0, irq_vector_take);
		for (i = 0; i < 40 && core_reset !== 1'h1; i++)
			step(1);
		chk("rst", 1'h1, core_reset);
		wdt_enable = 1'h0;
		$display("watchdog test done");
		clr_wdt;
		go_sleep(13'h0300);
		master_clear_pin = 1'h0;
		step(1);
		chk("rst", 1'h1, core_reset);
		chk("asleep", 1'h0, asleep);
		master_clear_pin = 1'h1;
		step(3);
		$display("master clear test done");
		end_of_test;
	end
endmodule
`default_nettype wire
